// [rtl/usf_status.sv]
// usf_status: status flags and receive error counts of a fifo serial port,
// with an avalon-mm slave for the 16-bit status word.
// assumes the shift engines, fifos and dma logic run on clk and hand over
// one-cycle event pulses and fifo levels on the same clock.
//
// Operation
// - 16-bit status: low byte operating flags, high byte rx fifo error counts.
// - resetn loads 0x0060: transmit end and tx empty set, rest clear.
// - standby leaves the status untouched; only resetn reinitialises it.
// - writing 0 clears a writable flag, writing 1 leaves it alone.
// - a zero write clears a flag only after software read it as 1.
// - per-byte framing and parity error flags are read-only.
// - bits 15:12 count held rx bytes with parity errors.
// - sixteen held bytes with parity errors read as a count of 0.
// - bits 11:8 count held rx bytes with framing errors.
// - sixteen held bytes with framing errors read as a count of 0.
// - receive fault sets when the sampled stop bit is 0.
// - with two stop bits only the first is checked.
// - clearing the receiver enable leaves the receive fault flag as is.
// - faulty bytes are still stored and reception continues.
// - transmit end sets when the last bit goes out and tx fifo is empty.
// - transmit end is held at 1 while the transmitter is off.
// - transmit end clears by software zero write or a dma tx write.
// - tx empty clears by software when level exceeds threshold, by dma when level reaches it.
// - receive fault clears by zero write after read of 1, or reset.
// - tx fifo holds 16 bytes; writes beyond that are dropped.
// - break sets on framing error then a frame of low; zero bytes dropped.
// - rx full flag sets when rx level reaches the receive threshold.
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns
module usf_status (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // avalon-mm slave
  input  wire logic [usf_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  // receiver side
  input  wire logic                        rx_char_done,
  input  wire logic [7:0]                  rx_data,
  input  wire logic                        rx_stop1,
  input  wire logic                        rx_parity_en,
  input  wire logic                        rx_parity_bit,
  input  wire logic                        rx_parity_odd,
  input  wire logic                        rx_frame_low,
  input  wire logic                        rx_line_mark,
  input  wire logic                        rx_pop,
  input  wire logic                        rx_pop_dma,
  input  wire logic [usf_pkg::CNT_W-1:0]   rx_level,
  input  wire logic [usf_pkg::CNT_W-1:0]   rx_threshold,
  input  wire logic                        rx_idle_timeout,
  // transmitter side
  input  wire logic                        tx_on_bit,
  input  wire logic                        tx_load,
  input  wire logic                        tx_last_bit,
  input  wire logic                        tx_push,
  input  wire logic                        tx_push_dma,
  input  wire logic [usf_pkg::CNT_W-1:0]   tx_level,
  input  wire logic [usf_pkg::CNT_W-1:0]   tx_threshold,
  // results
  output logic                             rx_store,
  output logic                             rx_store_fe,
  output logic                             rx_store_pe,
  output logic                             tx_write,
  output logic      [15:0]                 serial_port_status
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]                  flags;
    logic [7:0]                  armed;
    logic [usf_pkg::FIFO_DEPTH-1:0] fe_mem;
    logic [usf_pkg::FIFO_DEPTH-1:0] pe_mem;
    logic [usf_pkg::PTR_W-1:0]   wr_ptr;
    logic [usf_pkg::PTR_W-1:0]   rd_ptr;
    logic [usf_pkg::CNT_W-1:0]   held;
    logic [usf_pkg::CNT_W-1:0]   fe_cnt;
    logic [usf_pkg::CNT_W-1:0]   pe_cnt;
    logic                        last_fe;
    logic                        in_break;
    logic                        wait_n;
    logic [31:0]                 rdata;
    logic                        store;
    logic                        store_fe;
    logic                        store_pe;
    logic                        txw;
  } usf_state_t;

  usf_state_t st_r;
  usf_state_t st_nxt;

  logic [15:0] status_now;
  logic        fe_now;
  logic        pe_now;
  logic        push_ok;
  logic        pop_ok;
  logic        bus_req;
  logic        bus_take;
  logic        hit;
  logic [7:0]  zero_wr;
  logic [7:0]  sw_clr;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // head flags describe the byte that software reads next
    status_now = {st_r.pe_cnt[3:0], st_r.fe_cnt[3:0], st_r.flags};
    if (st_r.held != '0) begin
      status_now[usf_pkg::FER_POS] = st_r.fe_mem[st_r.rd_ptr];
      status_now[usf_pkg::PER_POS] = st_r.pe_mem[st_r.rd_ptr];
    end else begin
      status_now[usf_pkg::FER_POS] = 1'b0;
      status_now[usf_pkg::PER_POS] = 1'b0;
    end
  end

  always_comb begin
    st_nxt   = st_r;
    fe_now   = ~rx_stop1;
    pe_now   = rx_parity_en & ((^{rx_data, rx_parity_bit}) != rx_parity_odd);
    bus_req  = avs_read | avs_write;
    bus_take = bus_req & ~st_r.wait_n;
    hit      = avs_address == usf_pkg::STATUS_OFS;
    zero_wr  = avs_byteenable[0] ? ~avs_writedata[7:0] : 8'h00;
    sw_clr   = '0;
    if (bus_take && avs_write && hit) begin
      // a zero only counts where the flag was seen as one
      sw_clr = zero_wr & st_r.armed & usf_pkg::CLEARABLE_MASK;
    end

    // bus handshake: one wait cycle, then the access completes
    st_nxt.wait_n = ~(bus_req & st_r.wait_n);
    st_nxt.rdata  = '0;
    if (bus_req && st_r.wait_n && hit) begin
      st_nxt.rdata = {16'h0000, status_now};
    end
    if (bus_take && avs_read && hit) begin
      st_nxt.armed = st_r.armed | avs_readdata[7:0];
    end
    st_nxt.armed = st_nxt.armed & ~sw_clr;

    // receive side: break suppresses the zero bytes that follow it
    st_nxt.store    = 1'b0;
    st_nxt.store_fe = 1'b0;
    st_nxt.store_pe = 1'b0;
    push_ok = rx_char_done & ~(st_r.in_break & (rx_data == 8'h00));
    pop_ok  = (rx_pop | rx_pop_dma) & (st_r.held != '0);

    // software clears first so that a same-cycle set wins
    st_nxt.flags = st_r.flags & ~sw_clr;
    if (sw_clr[usf_pkg::TX_FIFO_EMPTY_FLAG_POS] && tx_level <= tx_threshold) begin
      st_nxt.flags[usf_pkg::TX_FIFO_EMPTY_FLAG_POS] = 1'b1;
    end
    if (sw_clr[usf_pkg::RDF_POS] && rx_level >= rx_threshold) begin
      st_nxt.flags[usf_pkg::RDF_POS] = 1'b1;
    end

    if (rx_char_done) begin
      st_nxt.last_fe = fe_now;
      // faulty bytes are kept, the engine carries on receiving
      if (fe_now || pe_now) begin
        st_nxt.flags[usf_pkg::ER_POS] = 1'b1;
      end
    end
    if (rx_frame_low && st_r.last_fe) begin
      st_nxt.flags[usf_pkg::BRK_POS] = 1'b1;
      st_nxt.in_break = 1'b1;
    end else if (rx_line_mark) begin
      st_nxt.in_break = 1'b0;
    end

    // per-byte error shadow of the rx fifo
    if (push_ok) begin
      st_nxt.store    = 1'b1;
      st_nxt.store_fe = fe_now;
      st_nxt.store_pe = pe_now;
    end
    if (push_ok && st_r.held < 5'(usf_pkg::FIFO_DEPTH)) begin
      st_nxt.fe_mem[st_r.wr_ptr] = fe_now;
      st_nxt.pe_mem[st_r.wr_ptr] = pe_now;
      st_nxt.wr_ptr = st_r.wr_ptr + 4'h1;
      st_nxt.held   = st_nxt.held + 5'h01;
      st_nxt.fe_cnt = st_nxt.fe_cnt + {4'h0, fe_now};
      st_nxt.pe_cnt = st_nxt.pe_cnt + {4'h0, pe_now};
    end
    if (pop_ok) begin
      st_nxt.rd_ptr = st_r.rd_ptr + 4'h1;
      st_nxt.held   = st_nxt.held - 5'h01;
      st_nxt.fe_cnt = st_nxt.fe_cnt - {4'h0, st_r.fe_mem[st_r.rd_ptr]};
      st_nxt.pe_cnt = st_nxt.pe_cnt - {4'h0, st_r.pe_mem[st_r.rd_ptr]};
    end
    // a count of 16 shows as 0 in the 4-bit field

    // rx fifo level flags
    if (rx_pop_dma && rx_level < rx_threshold) begin
      st_nxt.flags[usf_pkg::RDF_POS] = 1'b0;
    end
    if (rx_level >= rx_threshold) begin
      st_nxt.flags[usf_pkg::RDF_POS] = 1'b1;
    end
    if (rx_idle_timeout) begin
      st_nxt.flags[usf_pkg::DR_POS] = 1'b1;
    end

    // transmit side; dma writes clear without a prior read
    st_nxt.txw = (tx_push | tx_push_dma) & (tx_level < 5'(usf_pkg::FIFO_DEPTH));
    if (tx_push_dma) begin
      st_nxt.flags[usf_pkg::TRANSMIT_END_FLAG_POS] = 1'b0;
      if (tx_level >= tx_threshold) begin
        st_nxt.flags[usf_pkg::TX_FIFO_EMPTY_FLAG_POS] = 1'b0;
      end
    end
    if (tx_load && tx_level <= tx_threshold) begin
      st_nxt.flags[usf_pkg::TX_FIFO_EMPTY_FLAG_POS] = 1'b1;
    end
    if (tx_last_bit && tx_level == '0) begin
      st_nxt.flags[usf_pkg::TRANSMIT_END_FLAG_POS] = 1'b1;
    end
    if (!tx_on_bit) begin
      st_nxt.flags[usf_pkg::TRANSMIT_END_FLAG_POS] = 1'b1;
    end
    // receiver enable is deliberately not an input here
  end

  ////////////////////////////////////////////////////////////////////////////
  // no standby input: only resetn reinitialises the flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r          <= '0;
      st_r.flags    <= usf_pkg::STATUS_RESET[7:0];
      st_r.wait_n   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata       = st_r.rdata;
  assign avs_waitrequest    = st_r.wait_n;
  assign rx_store           = st_r.store;
  assign rx_store_fe        = st_r.store_fe;
  assign rx_store_pe        = st_r.store_pe;
  assign tx_write           = st_r.txw;
  assign serial_port_status = {st_r.pe_cnt[3:0], st_r.fe_cnt[3:0], st_r.flags};

endmodule : usf_status

// [rtl/usf_pkg.sv]
// usf_pkg: constants for the serial port status and error-count block.
// assumes a 32-bit avalon-mm slave with word addresses in bytes.
package usf_pkg;

  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  STATUS_OFS     = 4'h0;

  localparam logic [15:0] STATUS_RESET   = 16'h0060;

  // low byte flag positions and high byte count field lsbs
  localparam int          DR_POS         = 0;
  localparam int          RDF_POS        = 1;
  localparam int          PER_POS        = 2;
  localparam int          FER_POS        = 3;
  localparam int          BRK_POS        = 4;
  localparam int          TX_FIFO_EMPTY_FLAG_POS       = 5;
  localparam int          TRANSMIT_END_FLAG_POS       = 6;
  localparam int          ER_POS         = 7;
  localparam int          FER_CNT_LSB    = 8;
  localparam int          PER_CNT_LSB    = 12;

  // flags that take a zero write after a read of one
  localparam logic [7:0]  CLEARABLE_MASK = 8'hf3;

  localparam int          FIFO_DEPTH     = 16;
  localparam int          PTR_W          = 4;
  localparam int          CNT_W          = 5;

endpackage : usf_pkg

// [test/usf_status_monitor.sv]
// usf_status_monitor: port-level properties of the status block.
// assumes it is bound into usf_status and sees only its ports.
`timescale 1ns/1ns
module usf_status_monitor (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rx_char_done,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_stop1,
  input wire logic        rx_parity_en,
  input wire logic        rx_parity_bit,
  input wire logic        rx_parity_odd,
  input wire logic        tx_on_bit,
  input wire logic        tx_push,
  input wire logic        tx_push_dma,
  input wire logic [4:0]  tx_level,
  input wire logic        tx_write,
  input wire logic        rx_store,
  input wire logic        rx_store_fe,
  input wire logic        rx_store_pe,
  input wire logic [15:0] serial_port_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence bus_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence one_wait; !avs_waitrequest ##1 avs_waitrequest; endsequence
  ////////////////////////////////////////////////////////////////////////////
  rst_val_a: assert property ($rose(resetn) |-> serial_port_status == 16'h0060)
    else $error("status not at reset value");
  bus_wait_a: assert property (bus_req |=> one_wait)
    else $error("bus answer not one cycle");
  unmap_rd_a: assert property (
    avs_read && !avs_waitrequest && avs_address != 4'h0 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  rx_keep_a: assert property (rx_char_done && rx_data != 8'h00 |=> rx_store)
    else $error("received byte not stored");
  stop_err_a: assert property (
    rx_char_done && !rx_stop1 && rx_data != 8'h00 |=> rx_store_fe && serial_port_status[7])
    else $error("stop bit fault missed");
  par_err_a: assert property (
    rx_char_done && rx_parity_en && rx_data != 8'h00
    && ((^rx_data ^ rx_parity_bit) != rx_parity_odd)
    |=> rx_store_pe && serial_port_status[7]) else $error("parity fault missed");
  transmit_end_flag_hold_a: assert property (!tx_on_bit |=> serial_port_status[6])
    else $error("transmit end not held");
  tx_drop_a: assert property (
    tx_push && !tx_push_dma |=> tx_write == ($past(tx_level) != 5'h10))
    else $error("tx write accept wrong");
  ro_bits_a: assert property (serial_port_status[3:2] == 2'h0)
    else $error("read-only bits moved");
endmodule : usf_status_monitor

// [test/usf_partner.sv]
// usf_partner: remote transmitter, hands finished characters to the block.
// assumes the caller enters its tasks right after a rising clock edge.
`timescale 1ns/1ns
module usf_partner (
  input  wire logic  clk,
  output logic       rx_char_done,
  output logic [7:0] rx_data,
  output logic       rx_stop1,
  output logic       rx_parity_en,
  output logic       rx_parity_bit,
  output logic       rx_parity_odd,
  output logic       rx_frame_low,
  output logic       rx_line_mark
);
  initial begin
    {rx_char_done, rx_frame_low, rx_line_mark, rx_parity_odd} = 4'h0;
    {rx_data, rx_stop1, rx_parity_bit, rx_parity_en} = 11'h7ff;
  end
  // only the first stop bit is handed over; the second is never looked at
  task automatic send(input logic [7:0] d, input logic stop, input logic odd,
                      input logic bad);
    @(posedge clk);
    rx_char_done  <= 1'b1;
    rx_data       <= d;
    rx_stop1      <= stop;
    rx_parity_odd <= odd;
    rx_parity_bit <= ^d ^ odd ^ bad;
    @(posedge clk);
    rx_char_done  <= 1'b0;
    rx_data       <= ~d; // stale byte must not look valid
    rx_parity_bit <= ~rx_parity_bit;
  endtask : send
  task automatic break_detect_flag();
    @(posedge clk);
    rx_frame_low <= 1'b1;
    @(posedge clk);
    rx_frame_low <= 1'b0;
    send(8'h00, 1'b0, 1'b0, 1'b0);
    rx_line_mark <= 1'b1;
    @(posedge clk);
    rx_line_mark <= 1'b0;
  endtask : break_detect_flag
endmodule : usf_partner

// [test/test_usf_status.sv]
// test_usf_status: self-checking bench for the status block.
// assumes usf_partner drives the receive events; reads go through a queue.
`timescale 1ns/1ns
module test_usf_status;
  logic        clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest, tx_on_bit = 1'b0, rx_char_done, rx_stop1, rx_parity_en;
  logic        rx_parity_bit, rx_parity_odd, rx_frame_low, rx_line_mark, tx_write;
  logic        rx_store, rx_store_fe, rx_store_pe;
  logic [5:0]  evv = 6'h00;
  logic [4:0]  tx_level = 5'h00;
  logic [7:0]  rx_data;
  logic [15:0] serial_port_status;
  logic [31:0] expq[$];
  // waitrequest as it stands at the coming rising edge, free of the edge race
  logic        wait_mid = 1'b1;
  int          fail_count = 0;
  int          comparisons = 0;
  always #5 clk = ~clk;
  usf_partner rem (.clk, .rx_char_done, .rx_data, .rx_stop1, .rx_parity_en,
    .rx_parity_bit, .rx_parity_odd, .rx_frame_low, .rx_line_mark);
  usf_status dut (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .rx_char_done, .rx_data,
    .rx_stop1, .rx_parity_en, .rx_parity_bit, .rx_parity_odd, .rx_frame_low, .rx_line_mark,
    .rx_pop(evv[5]), .rx_pop_dma(evv[4]), .rx_level(5'h00), .rx_threshold(5'h08),
    .rx_idle_timeout(1'b0), .tx_on_bit, .tx_load(evv[3]), .tx_last_bit(evv[2]),
    .tx_push(evv[1]), .tx_push_dma(evv[0]), .tx_level, .tx_threshold(5'h04),
    .rx_store, .rx_store_fe, .rx_store_pe, .tx_write, .serial_port_status);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected status: expected %h seen %h", exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
                     input logic [15:0] e);
    if (!wr) expq.push_back({16'h0000, e});
    avs_address   <= a;
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= {16'h0000, d};
    do @(posedge clk); while (wait_mid !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic pulse(input logic [5:0] m);
    evv <= m;
    @(posedge clk);
    evv <= 6'h00;
    @(posedge clk);
  endtask : pulse
  task automatic results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  always @(negedge clk) wait_mid <= avs_waitrequest;
  // read data stand for the one cycle with waitrequest low; look mid-cycle
  always @(negedge clk)
    if (avs_read && avs_waitrequest === 1'b0 && expq.size() > 0)
      check(avs_readdata, expq.pop_front());
  initial begin
    #20000;
    fail_count++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(57));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(0, 4'h0, 16'h0, 16'h0060);
    rem.send(8'h5a, 1'b0, 1'b0, 1'b0);
    bus(1, 4'h0, 16'h0000, 16'h0);
    bus(0, 4'h0, 16'h0, 16'h01e8);
    bus(1, 4'h0, 16'h007f, 16'h0);
    bus(0, 4'h0, 16'h0, 16'h0168);
    for (int i = 0; i < 2; i++) rem.send(8'($urandom) | 8'h01, 1'b1, 1'(i), 1'b1);
    rem.send(8'h33, 1'b1, 1'b1, 1'b0);
    bus(0, 4'h0, 16'h0, 16'h21e8);
    pulse(6'h20);
    bus(0, 4'h0, 16'h0, 16'h20e4);
    pulse(6'h20);
    pulse(6'h10);
    bus(0, 4'h0, 16'h0, 16'h00e0);
    // empty the shadow so that all sixteen held bytes carry a framing error
    pulse(6'h20);
    repeat (16) rem.send(8'($urandom) | 8'h01, 1'b0, 1'b0, 1'b0);
    bus(0, 4'h0, 16'h0, 16'h00e8);
    rem.break_detect_flag();
    bus(0, 4'h0, 16'h0, 16'h00f8);
    tx_on_bit <= 1'b1;
    tx_level  <= 5'h04;
    pulse(6'h01);
    tx_level  <= 5'h10;
    pulse(6'h02);
    bus(0, 4'h0, 16'h0, 16'h0098);
    tx_level  <= 5'h02;
    pulse(6'h08);
    tx_level  <= 5'h00;
    pulse(6'h04);
    bus(0, 4'h0, 16'h0, 16'h00f8);
    bus(0, 4'h4, 16'h0, 16'h0000);
    bus(1, 4'h4, 16'h0000, 16'h0);
    bus(0, 4'h0, 16'h0, 16'h00f8);
    results();
  end
endmodule : test_usf_status
bind usf_status usf_status_monitor mon (.clk, .resetn, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .rx_char_done, .rx_data, .rx_stop1,
  .rx_parity_en, .rx_parity_bit, .rx_parity_odd, .tx_on_bit, .tx_push, .tx_push_dma,
  .tx_level, .tx_write, .rx_store, .rx_store_fe, .rx_store_pe, .serial_port_status);
